// ==== rtl/vdb_pkg.sv ====
// constants and types shared by the boot strap and input select block
package vdb_pkg;
  // register map, 16-bit sub address on the serial control link
  localparam logic [15:0] REG_VIDEO_INPUT_SELECT = 16'h0103;
  localparam logic [15:0] REG_CONV_CONFIG = 16'h0104;
  localparam logic [15:0] REG_GAIN_CONFIG = 16'h0105;
  localparam logic [15:0] REG_AUX_CLOCK = 16'h0106;
  localparam logic [15:0] REG_PIN_FUNCTION = 16'h0107;
  localparam logic [15:0] REG_GPIO = 16'h0108;
  localparam logic [15:0] REG_STATUS = 16'h0109;
  localparam logic [15:0] REG_PIN_LEVELS = 16'h010a;
  localparam logic [15:0] REG_ROUTE_BASE = 16'h0110;
  localparam logic [15:0] REG_ADDRSEL_ROUTE = 16'h0118;
  // reset values
  localparam logic [7:0] VIDEO_INPUT_SELECT_RESET = 8'h00;
  localparam logic [7:0] CONV_CONFIG_RESET = 8'h00;
  localparam logic [7:0] GAIN_CONFIG_RESET = 8'h80;
  localparam logic [7:0] AUX_CLOCK_RESET = 8'h03;
  localparam logic [7:0] PIN_FUNCTION_RESET = 8'h00;
  localparam logic [7:0] GPIO_RESET = 8'h00;
  localparam logic [3:0] ROUTE_RESET = 4'h8;
  localparam logic [7:0] ADDRSEL_ROUTE_RESET = 8'h00;
  // field positions in the input selection register
  localparam int CH_ONE_LSB = 0;
  localparam int CH_TWO_LSB = 4;
  localparam int CH_THREE_LSB = 6;
  // fields of the other registers
  localparam int GAIN_AUTO_BIT = 7;
  localparam int ADC2_MODE_LSB = 6;
  localparam int AUX_RATIO_BIT = 0;
  localparam int AUX_LOCKED_BIT = 1;
  localparam int GPIO_DIR_LSB = 4;
  localparam int ROUTE_INPUT_BIT = 3;
  localparam int ADDRSEL_DRIVE_BIT = 2;
  // anti-alias filter codes
  localparam logic [1:0] FILTER_8MHZ = 2'h0;
  localparam logic [1:0] FILTER_HALF = 2'h1;
  localparam logic [1:0] FILTER_BYPASS = 2'h2;
  // pin function codes for the infrared and interrupt pins
  localparam logic [1:0] PIN_NATIVE = 2'h0;
  localparam logic [1:0] PIN_GPIO = 2'h1;
  localparam logic [1:0] PIN_TIMING = 2'h2;
  // serial slave address upper five bits
  localparam logic [4:0] SLAVE_ADDR_HIGH = 5'h11;
  // synchroniser: 0 ir tx, 1 irq, 2 ir rx, 3 addr select, 4 scl, 5 sda, 6 sleep, 7 test, 15:8 pins
  localparam int SYNC_WIDTH = 16;
  localparam logic [15:0] SYNC_RESET = 16'h0030;
  localparam logic [2:0] STRAP_SETTLE_CYCLES = 3'h4;
  // decoder clock: eight times the 13.5 MHz pixel rate
  localparam int PIXEL_RATE_KHZ = 13500;
  localparam int DECODER_CLOCK_KHZ = 108000;
  localparam logic [3:0] PLL_MULTIPLIER = 4'(DECODER_CLOCK_KHZ / PIXEL_RATE_KHZ);
  localparam logic [15:0] PLL_FRACTION_RESET = 16'h8000;
  localparam logic [15:0] PLL_NUDGE_STEP = 16'h0001;
  typedef enum logic [2:0] {SL_IDLE, SL_DEV, SL_SUBH, SL_SUBL, SL_WRITE, SL_READ} vdb_serial_type;
endpackage : vdb_pkg

// ==== rtl/vdb_boot_strap.sv ====
// boot strap capture, control link, pin muxing and analog input select
`timescale 1ns/1ps
`default_nettype none
module vdb_boot_strap (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic serial_clock_in,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe_out,
  input wire logic address_select_pin_in,
  output logic address_select_pin_out,
  output logic address_select_pin_oe_out,
  input wire logic infrared_transmit_pin_in,
  output logic infrared_transmit_out,
  output logic infrared_transmit_oe_out,
  input wire logic infrared_receive_in,
  output logic infrared_receive_pin_out,
  output logic infrared_receive_oe_out,
  output logic infrared_receive_data_out,
  input wire logic interrupt_out_low_pin_in,
  output logic interrupt_out_low_out,
  output logic interrupt_out_low_oe_out,
  output logic host_port_interrupt_low_out,
  input wire logic sleep_in,
  input wire logic test_in,
  input wire logic [7:0] multipurpose_pin_in,
  output logic [7:0] multipurpose_pin_out,
  output logic [7:0] multipurpose_pin_oe_out,
  input wire logic [7:0] route_source_in,
  input wire logic [3:0] addrsel_source_in,
  input wire logic [2:0] timing_source_in,
  input wire logic interrupt_pending_in,
  input wire logic infrared_transmit_data_in,
  input wire logic [5:0] loop_gain_in,
  input wire logic pll_nudge_up_in,
  input wire logic pll_nudge_down_in,
  output logic host_port_mode_out,
  output logic alternate_address_out,
  output logic power_down_out,
  output logic test_mode_out,
  output logic [7:0] channel_one_source_out,
  output logic [2:0] channel_two_source_out,
  output logic [1:0] channel_three_source_out,
  output logic [1:0] adc2_mode_out,
  output logic [5:0] filter_select_out,
  output logic [5:0] gain_out,
  output logic aux_ratio_384_out,
  output logic aux_video_locked_out,
  output logic [3:0] pll_multiplier_out,
  output logic [15:0] pll_fraction_out
);
  import vdb_pkg::*;

  // returns {output enable, level} for a pin that may be native, gpio or timing
  function automatic logic [1:0] pin_drive(input logic [1:0] func, input logic native_oe,
                                           input logic native_val, input logic gpio_dir,
                                           input logic gpio_val, input logic timing);
    logic [1:0] r;
    r = {native_oe, native_val};
    if (func == PIN_GPIO) begin
      r = {gpio_dir, gpio_val};
    end else if (func == PIN_TIMING) begin
      r = {1'b1, timing};
    end
    return r;
  endfunction : pin_drive

  ////////////////////////////////////////////////////////////////////////////
  // three-stage synchronisers; a level counts once stages two and three agree
  logic [SYNC_WIDTH-1:0] raw_pins;
  logic [SYNC_WIDTH-1:0] sync_a;
  logic [SYNC_WIDTH-1:0] sync_b;
  logic [SYNC_WIDTH-1:0] sync_c;
  logic [SYNC_WIDTH-1:0] pin_level;

  assign raw_pins = {multipurpose_pin_in, test_in, sleep_in, serial_data_in, serial_clock_in,
                     address_select_pin_in, infrared_receive_in, interrupt_out_low_pin_in,
                     infrared_transmit_pin_in};

  genvar g;
  generate
    for (g = 0; g < SYNC_WIDTH; g++) begin : gen_sync
      always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
          sync_a[g] <= SYNC_RESET[g];
          sync_b[g] <= SYNC_RESET[g];
          sync_c[g] <= SYNC_RESET[g];
          pin_level[g] <= SYNC_RESET[g];
        end else begin
          sync_a[g] <= raw_pins[g];
          sync_b[g] <= sync_a[g];
          sync_c[g] <= sync_b[g];
          if (sync_b[g] == sync_c[g]) begin
            pin_level[g] <= sync_c[g];
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // strap capture after release; strap pins stay undriven until then
  logic [2:0] settle_count;
  logic strap_done;

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      settle_count <= 3'h0;
      strap_done <= 1'b0;
      host_port_mode_out <= 1'b0;
      alternate_address_out <= 1'b0;
    end else if (!strap_done) begin
      // waits for the filtered pin levels to reach the released pin state
      if (settle_count == STRAP_SETTLE_CYCLES) begin
        strap_done <= 1'b1;
        host_port_mode_out <= ~pin_level[0];
        alternate_address_out <= ~pin_level[1];
      end else begin
        settle_count <= settle_count + 3'h1;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      power_down_out <= 1'b0;
      test_mode_out <= 1'b0;
    end else begin
      power_down_out <= pin_level[6];
      test_mode_out <= pin_level[7];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // two-wire serial slave, idle in host port mode
  logic [7:0] video_input_select;
  logic [7:0] conv_config;
  logic [7:0] gain_config;
  logic [7:0] aux_clock;
  logic [7:0] pin_function;
  logic [7:0] gpio;
  logic [3:0] route [8];
  logic [7:0] addrsel_route;
  vdb_serial_type state;
  logic scl_d;
  logic sda_d;
  logic [2:0] bit_count;
  logic [7:0] shift;
  logic [7:0] read_shift;
  logic [15:0] sub_addr;
  logic ack_pend;
  logic in_ack;
  logic wr_pulse;
  logic [15:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_word;
  logic [6:0] slave_addr;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  assign slave_addr = {SLAVE_ADDR_HIGH, alternate_address_out, pin_level[3]};
  assign scl_rise = pin_level[4] & ~scl_d;
  assign scl_fall = ~pin_level[4] & scl_d;
  assign start_seen = pin_level[4] & scl_d & sda_d & ~pin_level[5] & strap_done
                      & ~host_port_mode_out;
  assign stop_seen = pin_level[4] & scl_d & ~sda_d & pin_level[5];

  always_comb begin
    rd_word = 8'h00;
    if (sub_addr == REG_VIDEO_INPUT_SELECT) rd_word = video_input_select;
    else if (sub_addr == REG_CONV_CONFIG) rd_word = conv_config;
    else if (sub_addr == REG_GAIN_CONFIG) rd_word = gain_config;
    else if (sub_addr == REG_AUX_CLOCK) rd_word = aux_clock;
    else if (sub_addr == REG_PIN_FUNCTION) rd_word = pin_function;
    else if (sub_addr == REG_GPIO) rd_word = gpio;
    else if (sub_addr == REG_STATUS) rd_word = {2'h0, pin_level[7:6], pin_level[2],
                                                pin_level[3], host_port_mode_out,
                                                alternate_address_out};
    else if (sub_addr == REG_PIN_LEVELS) rd_word = pin_level[15:8];
    else if (sub_addr[15:3] == REG_ROUTE_BASE[15:3]) rd_word = {4'h0, route[sub_addr[2:0]]};
    else if (sub_addr == REG_ADDRSEL_ROUTE) rd_word = addrsel_route;
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= pin_level[4];
      sda_d <= pin_level[5];
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= SL_IDLE;
      bit_count <= 3'h0;
      shift <= 8'h00;
      read_shift <= 8'h00;
      sub_addr <= 16'h0000;
      ack_pend <= 1'b0;
      in_ack <= 1'b0;
      serial_data_oe_out <= 1'b0;
      wr_pulse <= 1'b0;
      wr_addr <= 16'h0000;
      wr_data <= 8'h00;
    end else begin
      wr_pulse <= 1'b0;
      if (start_seen) begin
        state <= SL_DEV;
        bit_count <= 3'h0;
        ack_pend <= 1'b0;
        in_ack <= 1'b0;
        serial_data_oe_out <= 1'b0;
      end else if (stop_seen) begin
        state <= SL_IDLE;
        ack_pend <= 1'b0;
        in_ack <= 1'b0;
        serial_data_oe_out <= 1'b0;
      end else if (state != SL_IDLE) begin
        if (scl_rise) begin
          if (in_ack) begin
            // master nack ends a read burst
            if (state == SL_READ && pin_level[5]) state <= SL_IDLE;
          end else begin
            shift <= {shift[6:0], pin_level[5]};
            bit_count <= bit_count + 3'h1;
            if (bit_count == 3'h7) ack_pend <= 1'b1;
          end
        end else if (scl_fall) begin
          if (ack_pend) begin
            ack_pend <= 1'b0;
            in_ack <= 1'b1;
            serial_data_oe_out <= (state != SL_READ);
            case (state)
              SL_DEV: begin
                if (shift[7:1] == slave_addr) begin
                  state <= shift[0] ? SL_READ : SL_SUBH;
                end else begin
                  state <= SL_IDLE;
                  serial_data_oe_out <= 1'b0;
                end
              end
              SL_SUBH: begin
                sub_addr[15:8] <= shift;
                state <= SL_SUBL;
              end
              SL_SUBL: begin
                sub_addr[7:0] <= shift;
                state <= SL_WRITE;
              end
              SL_WRITE: begin
                wr_pulse <= 1'b1;
                wr_addr <= sub_addr;
                wr_data <= shift;
                sub_addr <= sub_addr + 16'h0001;
              end
              default: begin
              end
            endcase
          end else if (in_ack) begin
            in_ack <= 1'b0;
            bit_count <= 3'h0;
            if (state == SL_READ) begin
              read_shift <= rd_word;
              serial_data_oe_out <= ~rd_word[7];
              sub_addr <= sub_addr + 16'h0001;
            end else begin
              serial_data_oe_out <= 1'b0;
            end
          end else if (state == SL_READ) begin
            serial_data_oe_out <= ~read_shift[6];
            read_shift <= {read_shift[6:0], 1'b0};
          end
        end
      end
    end
  end

  // open-drain data line only ever pulls low
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) serial_data_out <= 1'b0;
    else serial_data_out <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      video_input_select <= VIDEO_INPUT_SELECT_RESET;
      conv_config <= CONV_CONFIG_RESET;
      gain_config <= GAIN_CONFIG_RESET;
      aux_clock <= AUX_CLOCK_RESET;
      pin_function <= PIN_FUNCTION_RESET;
      gpio <= GPIO_RESET;
      addrsel_route <= ADDRSEL_ROUTE_RESET;
      for (int i = 0; i < 8; i++) route[i] <= ROUTE_RESET;
    end else if (wr_pulse) begin
      if (wr_addr == REG_VIDEO_INPUT_SELECT) video_input_select <= wr_data;
      if (wr_addr == REG_CONV_CONFIG) conv_config <= wr_data;
      if (wr_addr == REG_GAIN_CONFIG) gain_config <= wr_data;
      if (wr_addr == REG_AUX_CLOCK) aux_clock <= wr_data;
      if (wr_addr == REG_PIN_FUNCTION) pin_function <= wr_data;
      if (wr_addr == REG_GPIO) gpio <= wr_data;
      if (wr_addr == REG_ADDRSEL_ROUTE) addrsel_route <= wr_data;
      if (wr_addr[15:3] == REG_ROUTE_BASE[15:3]) route[wr_addr[2:0]] <= wr_data[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // analog input mux; a one-hot switch enable per input, none on reserved codes
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      channel_one_source_out <= 8'h00;
      channel_two_source_out <= 3'h0;
      channel_three_source_out <= 2'h0;
    end else begin
      channel_one_source_out <= 8'h01 << video_input_select[CH_ONE_LSB +: 3];
      case (video_input_select[CH_TWO_LSB +: 2])
        2'h0: channel_two_source_out <= 3'h1;
        2'h1: channel_two_source_out <= 3'h2;
        2'h2: channel_two_source_out <= 3'h4;
        default: channel_two_source_out <= 3'h0;
      endcase
      case (video_input_select[CH_THREE_LSB +: 2])
        2'h0: channel_three_source_out <= 2'h1;
        2'h1: channel_three_source_out <= 2'h2;
        default: channel_three_source_out <= 2'h0;
      endcase
    end
  end

  // converter one is hard-wired to channel one; only converter two has a mode
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      adc2_mode_out <= 2'h0;
      filter_select_out <= 6'h00;
      gain_out <= 6'h00;
      aux_ratio_384_out <= 1'b1;
      aux_video_locked_out <= 1'b1;
      pll_multiplier_out <= 4'h0;
    end else begin
      adc2_mode_out <= conv_config[ADC2_MODE_LSB +: 2];
      filter_select_out <= conv_config[5:0];
      gain_out <= gain_config[GAIN_AUTO_BIT] ? loop_gain_in : gain_config[5:0];
      aux_ratio_384_out <= aux_clock[AUX_RATIO_BIT];
      aux_video_locked_out <= aux_clock[AUX_LOCKED_BIT];
      pll_multiplier_out <= PLL_MULTIPLIER;
    end
  end

  // fractional word wraps rather than saturates; the loop keeps it mid-range
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pll_fraction_out <= PLL_FRACTION_RESET;
    end else if (pll_nudge_up_in && !pll_nudge_down_in) begin
      pll_fraction_out <= pll_fraction_out + PLL_NUDGE_STEP;
    end else if (pll_nudge_down_in && !pll_nudge_up_in) begin
      pll_fraction_out <= pll_fraction_out - PLL_NUDGE_STEP;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin functions; nothing drives a strap pin before the straps are taken
  logic [1:0] tx_drive;
  logic [1:0] rx_drive;
  logic [1:0] irq_drive;

  assign tx_drive = pin_drive(pin_function[1:0], 1'b1, infrared_transmit_data_in,
                              gpio[GPIO_DIR_LSB], gpio[0], timing_source_in[0]);
  assign rx_drive = pin_drive(pin_function[3:2], 1'b0, 1'b0,
                              gpio[GPIO_DIR_LSB + 1], gpio[1], timing_source_in[1]);
  assign irq_drive = pin_drive(pin_function[5:4], 1'b1, ~interrupt_pending_in,
                               gpio[GPIO_DIR_LSB + 2], gpio[2], timing_source_in[2]);

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      infrared_transmit_out <= 1'b1;
      infrared_transmit_oe_out <= 1'b0;
      infrared_receive_pin_out <= 1'b0;
      infrared_receive_oe_out <= 1'b0;
      infrared_receive_data_out <= 1'b1;
      interrupt_out_low_out <= 1'b1;
      interrupt_out_low_oe_out <= 1'b0;
      host_port_interrupt_low_out <= 1'b1;
    end else begin
      infrared_transmit_out <= tx_drive[0];
      infrared_transmit_oe_out <= tx_drive[1] & strap_done;
      infrared_receive_pin_out <= rx_drive[0];
      infrared_receive_oe_out <= rx_drive[1] & strap_done;
      infrared_receive_data_out <= pin_level[2];
      interrupt_out_low_out <= irq_drive[0];
      interrupt_out_low_oe_out <= irq_drive[1] & strap_done;
      host_port_interrupt_low_out <= ~(host_port_mode_out & interrupt_pending_in);
    end
  end

  generate
    for (g = 0; g < 8; g++) begin : gen_route
      always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
          multipurpose_pin_out[g] <= 1'b0;
          multipurpose_pin_oe_out[g] <= 1'b0;
        end else begin
          multipurpose_pin_out[g] <= route_source_in[route[g][2:0]];
          multipurpose_pin_oe_out[g] <= ~route[g][ROUTE_INPUT_BIT] & strap_done;
        end
      end
    end
  endgenerate

  // address select drives its routed source when addrsel_route bit 2 is set, which only serial mode can write, and is an input otherwise
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      address_select_pin_out <= 1'b0;
      address_select_pin_oe_out <= 1'b0;
    end else begin
      address_select_pin_out <= addrsel_source_in[addrsel_route[1:0]];
      address_select_pin_oe_out <= addrsel_route[ADDRSEL_DRIVE_BIT] & strap_done;
    end
  end
endmodule : vdb_boot_strap
`default_nettype wire

// ==== bench/vdb_boot_strap_chk.sv ====
// assertion checker for the boot strap and input select block
`timescale 1ns/1ps
`default_nettype none
module vdb_boot_strap_chk (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic infrared_transmit_pin_in,
  input wire logic interrupt_out_low_pin_in,
  input wire logic sleep_in,
  input wire logic interrupt_pending_in,
  input wire logic pll_nudge_up_in,
  input wire logic pll_nudge_down_in,
  input wire logic host_port_mode_out,
  input wire logic alternate_address_out,
  input wire logic power_down_out,
  input wire logic host_port_interrupt_low_out,
  input wire logic [7:0] channel_one_source_out,
  input wire logic [2:0] channel_two_source_out,
  input wire logic [3:0] pll_multiplier_out,
  input wire logic [15:0] pll_fraction_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  // cycles since reset release, saturating
  logic [3:0] age;
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      age <= 4'h0;
    end else if (age != 4'hf) begin
      age <= age + 4'h1;
    end
  end
  sequence s_sleep_held;
    sleep_in [*8];
  endsequence
  sequence s_irq_held;
    (host_port_mode_out && interrupt_pending_in) [*4];
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  strap_mode_a: assert property (age == 4'h8 |->
    host_port_mode_out == !$past(infrared_transmit_pin_in, 4)) else $error("mode strap wrong");
  strap_addr_a: assert property (age == 4'h8 |->
    alternate_address_out == !$past(interrupt_out_low_pin_in, 4)) else $error("addr strap wrong");
  strap_hold_a: assert property (age == 4'hf |-> $stable(host_port_mode_out)
    && $stable(alternate_address_out)) else $error("strap changed");
  sleep_enter_a: assert property (s_sleep_held |-> power_down_out)
    else $error("no power down");
  sleep_leave_a: assert property ($fell(sleep_in) |-> ##[1:8] !power_down_out)
    else $error("power down stuck");
  host_irq_a: assert property (!host_port_interrupt_low_out |-> host_port_mode_out)
    else $error("host irq outside host mode");
  host_irq_on_a: assert property (s_irq_held |-> !host_port_interrupt_low_out)
    else $error("host irq missing");
  source_hot_a: assert property ($onehot0(channel_one_source_out)
    && $onehot0(channel_two_source_out)) else $error("two inputs on one channel");
  pll_mult_a: assert property ($past(rstn_in) |-> pll_multiplier_out == 4'h8)
    else $error("pll multiplier wrong");
  nudge_up_a: assert property (pll_nudge_up_in && !pll_nudge_down_in |=>
    pll_fraction_out == $past(pll_fraction_out) + 16'h1) else $error("nudge up wrong");
  nudge_idle_a: assert property (!pll_nudge_up_in && !pll_nudge_down_in |=>
    $stable(pll_fraction_out)) else $error("fraction drifted");
endmodule : vdb_boot_strap_chk
bind vdb_boot_strap vdb_boot_strap_chk u_chk (.*);
`default_nettype wire

// ==== bench/vdb_serial_host.sv ====
// two-wire serial host model driving the control link
`timescale 1ns/1ps
`default_nettype none
module vdb_serial_host (
  output logic scl_out,
  output logic sda_low_out,
  input wire logic sda_in
);
  localparam realtime QTR = 31.25;
  logic [7:0] rx;
  logic ack;
  // clock idles high between frames
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic start();
    sda_low_out = 1'b0;
    #QTR scl_out = 1'b1;
    #QTR sda_low_out = 1'b1;
    #QTR scl_out = 1'b0;
    #QTR;
  endtask : start
  task automatic stop();
    sda_low_out = 1'b1;
    #QTR scl_out = 1'b1;
    #QTR sda_low_out = 1'b0;
    #(2 * QTR);
  endtask : stop
  // ninth bit released: ack from device on writes, nack from us on reads
  task automatic xfer(input logic [7:0] tx);
    for (int i = 8; i >= 0; i--) begin
      sda_low_out = (i > 0) ? !tx[i - 1] : 1'b0;
      #QTR scl_out = 1'b1;
      #QTR;
      if (i > 0) rx[i - 1] = sda_in;
      else ack = !sda_in;
      #QTR scl_out = 1'b0;
      #QTR;
    end
  endtask : xfer
endmodule : vdb_serial_host
`default_nettype wire

// ==== bench/testbench.sv ====
// self-checking bench for the boot strap and input select block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import vdb_pkg::*;
  logic clock_in, rstn_in, serial_clock_in, serial_data_in, address_select_pin_in, test_in;
  logic infrared_transmit_pin_in, infrared_receive_in, interrupt_out_low_pin_in, sleep_in;
  logic interrupt_pending_in, infrared_transmit_data_in, pll_nudge_up_in, pll_nudge_down_in;
  logic serial_data_out, serial_data_oe_out, address_select_pin_out, address_select_pin_oe_out;
  logic infrared_transmit_out, infrared_transmit_oe_out, infrared_receive_pin_out;
  logic infrared_receive_oe_out, infrared_receive_data_out, interrupt_out_low_out;
  logic interrupt_out_low_oe_out, host_port_interrupt_low_out, host_port_mode_out;
  logic alternate_address_out, power_down_out, test_mode_out, aux_ratio_384_out;
  logic aux_video_locked_out, strap_ir, strap_irq, sel, host_low, a;
  logic [1:0] adc2_mode_out, channel_three_source_out;
  logic [2:0] timing_source_in, channel_two_source_out, k;
  logic [3:0] addrsel_source_in, pll_multiplier_out;
  logic [5:0] loop_gain_in, filter_select_out, gain_out;
  logic [7:0] multipurpose_pin_in, multipurpose_pin_out, multipurpose_pin_oe_out, route_source_in;
  logic [7:0] channel_one_source_out, v;
  logic [7:0] tick = 8'h00;
  logic [15:0] pll_fraction_out;
  int error_cnt, samples_checked;
  // pull-up on data; pins other than infrared receive read back whatever drives them
  assign serial_data_in = !(host_low || (serial_data_oe_out && !serial_data_out));
  assign infrared_transmit_pin_in = infrared_transmit_oe_out ? infrared_transmit_out : strap_ir;
  assign interrupt_out_low_pin_in = interrupt_out_low_oe_out ? interrupt_out_low_out : strap_irq;
  assign address_select_pin_in = address_select_pin_oe_out ? address_select_pin_out : sel;
  assign multipurpose_pin_in = (multipurpose_pin_oe_out & multipurpose_pin_out)
    | (~multipurpose_pin_oe_out & tick);
  assign route_source_in = tick;
  assign addrsel_source_in = tick[3:0];
  assign timing_source_in = tick[2:0];
  assign infrared_transmit_data_in = tick[0];
  assign infrared_receive_in = tick[1];
  vdb_boot_strap u_vdb_boot_strap (.*);
  vdb_serial_host u_host (.scl_out(serial_clock_in), .sda_low_out(host_low), .sda_in(serial_data_in));
  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end
  always @(posedge clock_in) tick <= tick + 8'h1;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask : step
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic boot(input logic ir, input logic irq);
    rstn_in = 1'b0;
    strap_ir = ir;
    strap_irq = irq;
    step(12);
    rstn_in = 1'b1;
    step(12);
  endtask : boot
  task automatic acc(input logic [7:0] dev, input logic [15:0] sub, input logic [7:0] d,
                     input logic rd);
    u_host.start();
    u_host.xfer(dev);
    a = u_host.ack;
    u_host.xfer(sub[15:8]);
    u_host.xfer(sub[7:0]);
    if (rd) begin
      u_host.start();
      u_host.xfer(dev | 8'h01);
      u_host.xfer(8'hff);
    end else begin
      u_host.xfer(d);
    end
    u_host.stop();
    step(4);
  endtask : acc
  task automatic results();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rstn_in, sel, sleep_in, test_in, interrupt_pending_in} = 5'h00;
    {pll_nudge_up_in, pll_nudge_down_in, loop_gain_in} = {2'h0, 6'h2a};
    boot(1'b1, 1'b1);
    chk(host_port_mode_out, 0);
    chk(alternate_address_out, 0);
    chk(gain_out, 6'h2a);
    for (int n = 0; n < 8; n++) begin
      k = 3'(n);
      v = {k[1:0], k[1:0], 1'b0, k};
      acc(8'h88, REG_VIDEO_INPUT_SELECT, v, 1'b0);
      chk(a, 1);
      chk(channel_one_source_out, 8'h01 << k);
      chk(channel_two_source_out, (k[1:0] == 2'h3) ? 3'h0 : 3'h1 << k[1:0]);
      chk(channel_three_source_out, k[1] ? 2'h0 : 2'h1 << k[0]);
      acc(8'h88, REG_VIDEO_INPUT_SELECT, 8'h00, 1'b1);
      chk(u_host.rx, v);
    end
    acc(8'h8c, REG_VIDEO_INPUT_SELECT, 8'h00, 1'b1);
    chk(a, 0);
    sel = 1'b1;
    acc(8'h8a, 16'h0200, 8'h00, 1'b1);
    chk(a, 1);
    chk(u_host.rx, 8'h00);
    acc(8'h8a, 16'h0104, 8'h46, 1'b0);
    chk(filter_select_out, 6'h06);
    chk(adc2_mode_out, 2'h1);
    acc(8'h8a, 16'h0105, 8'h15, 1'b0);
    chk(gain_out, 6'h15);
    acc(8'h8a, 16'h0106, 8'h02, 1'b0);
    chk({aux_ratio_384_out, aux_video_locked_out}, 2'h1);
    acc(8'h8a, 16'h0107, 8'h04, 1'b0);
    acc(8'h8a, 16'h0108, 8'h22, 1'b0);
    chk({infrared_receive_pin_out, infrared_receive_oe_out}, 2'h3);
    acc(8'h8a, 16'h0110, 8'h03, 1'b0);
    chk(multipurpose_pin_oe_out, 8'h01);
    interrupt_pending_in = 1'b1;
    step(6);
    chk({interrupt_out_low_out, host_port_interrupt_low_out}, 2'h1);
    interrupt_pending_in = 1'b0;
    step(6);
    chk(interrupt_out_low_out, 1);
    pll_nudge_up_in = 1'b1;
    step(2);
    {pll_nudge_up_in, pll_nudge_down_in} = 2'h1;
    step(1);
    pll_nudge_down_in = 1'b0;
    step(2);
    chk(pll_fraction_out, 16'h8001);
    {sleep_in, test_in} = 2'h3;
    step(10);
    chk({power_down_out, test_mode_out}, 2'h3);
    {sleep_in, test_in} = 2'h0;
    step(10);
    chk({power_down_out, test_mode_out}, 2'h0);
    boot(1'b1, 1'b0);
    chk(alternate_address_out, 1);
    acc(8'h8e, REG_VIDEO_INPUT_SELECT, 8'h00, 1'b1);
    chk({a, u_host.rx}, 9'h100);
    boot(1'b0, 1'b1);
    chk(host_port_mode_out, 1);
    acc(8'h8a, REG_VIDEO_INPUT_SELECT, 8'h55, 1'b0);
    chk(a, 0);
    interrupt_pending_in = 1'b1;
    step(6);
    chk(host_port_interrupt_low_out, 0);
    results();
  end
  initial begin
    repeat (90000) @(posedge clock_in);
    error_cnt++;
    results();
  end
endmodule : testbench
`default_nettype wire
